// [hw/bgdbg_pkg.sv]
/*
  Package for the background debug controller register block: field positions,
  reset values, serial command codes and the grouped carrier types.
  Assumes the serial command decoder and the core status signals live outside.
*/
// Notes on behaviour
// - An 8-bit status/control register reached only by serial debug commands, no address.
// - A 16-bit breakpoint address register read and written by breakpoint commands.
// - User program accesses never reach either debug register.
// - Permit bit 7 ignores writes while background state is active.
// - Permit bit once set stays 1 until normal reset; 0 blocks background entry.
// - Four status bits are read-only; control write never changes them.
// - Bit 6 reads 1 while background state active, 0 while user program runs.
// - Breakpoint enable bit 5 low disables breakpoint, ignoring force/tag and address.
// - Force mode match requests background entry at next instruction boundary.
// - Tag mode match tags the opcode; background entry if it reaches queue end.
// - Clock select bit 3 always read/write, resets 0 for alternate clock.
// - Background command forces core out of wait or stop into background state.
// - Bit 2 reads 1 in wait/stop or after background command left wait/stop.
// - Bit 1 sets when a memory access command fails due to wait/stop.
// - Data valid failure bit has no function here, no slow memory.
package bgdbg_pkg;
  localparam int unsigned CTL_W         = 8;
  localparam int unsigned BKPT_W        = 16;
  localparam int unsigned PERMIT_BIT    = 7;
  localparam int unsigned ACTIVE_BIT    = 6;
  localparam int unsigned BKPT_EN_BIT   = 5;
  localparam int unsigned FTS_BIT       = 4;
  localparam int unsigned CLKSEL_BIT    = 3;
  localparam int unsigned WS_BIT        = 2;
  localparam int unsigned WSF_BIT       = 1;
  localparam int unsigned DVF_BIT       = 0;
  localparam logic        PERMIT_RST    = 1'b0;
  localparam logic        BKPT_EN_RST   = 1'b0;
  localparam logic        FTS_RST       = 1'b0;
  localparam logic        CLKSEL_RST    = 1'b0;
  localparam logic [15:0] BKPT_ADDR_RST = 16'h0000;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_READ_STATUS,
    CMD_WRITE_CONTROL,
    CMD_BKPT_READ,
    CMD_BKPT_WRITE,
    CMD_BACKGROUND
  } cmd_t;

  typedef struct packed {
    cmd_t        cmd;
    logic [15:0] wdata;
  } serial_req_t;

  typedef struct packed {
    logic        in_wait_stop;
    logic        mem_cmd_fail_ws;
    logic        instr_boundary;
    logic        opcode_fetch;
    logic        queue_end_tagged;
    logic [15:0] addr;
  } core_stat_t;
endpackage

// [hw/background_debug_control_regs.sv]
/*
  Background debug controller registers: status/control byte and breakpoint
  match address, reached only through a decoded serial command port.
  Assumes the serial decoder presents one-cycle command strobes and that the core
  reports wait/stop, instruction boundaries and queue-end of tagged opcodes.
*/
`timescale 1ns/1ps
`default_nettype none
module background_debug_control_regs #(
  parameter int unsigned CTL_W  = bgdbg_pkg::CTL_W,
  parameter int unsigned BKPT_W = bgdbg_pkg::BKPT_W
) (
  input  wire logic                    clk_i,
  input  wire logic                    resetn_i,
  input  wire bgdbg_pkg::serial_req_t  req_i,
  input  wire bgdbg_pkg::core_stat_t   core_i,
  input  wire logic                    resume_i,
  output logic [15:0]                  rdata_o,
  output logic                         rvalid_o,
  output logic                         enter_bg_o,
  output logic                         tag_opcode_o,
  output logic                         bg_active_o,
  output logic                         comm_clk_bus_o
);
  logic              permit_r;
  logic              bkpt_en_r;
  logic              fts_r;
  logic              clksel_r;
  logic              active_r;
  logic              ws_latched_r;
  logic              wsf_r;
  logic              force_pend_r;
  logic [BKPT_W-1:0] bkpt_addr_r;
  logic [BKPT_W-1:0] rdata_r;
  logic              rvalid_r;
  logic              enter_bg_r;
  logic              tag_r;
  logic [CTL_W-1:0]  status_byte;
  logic              match;
  logic              bg_cmd;
  logic              ctl_wr;
  logic              enter_nxt;

  // Carrier structs fix both widths, so no other value can be served
  if (CTL_W != bgdbg_pkg::CTL_W) begin : g_ctl_w_check
    $error("status register width must match the serial carrier");
  end
  if (BKPT_W != bgdbg_pkg::BKPT_W) begin : g_bkpt_w_check
    $error("breakpoint width must match the serial carrier");
  end
  if (bgdbg_pkg::PERMIT_BIT >= CTL_W) begin : g_field_check
    $error("status fields must fit the status register");
  end

  // No user bus port exists, so user code cannot reach these registers
  assign ctl_wr = (req_i.cmd == bgdbg_pkg::CMD_WRITE_CONTROL);
  assign bg_cmd = (req_i.cmd == bgdbg_pkg::CMD_BACKGROUND) && permit_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      permit_r <= bgdbg_pkg::PERMIT_RST;
    end else if (ctl_wr && !active_r && req_i.wdata[bgdbg_pkg::PERMIT_BIT]) begin
      permit_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bkpt_en_r <= bgdbg_pkg::BKPT_EN_RST;
      fts_r     <= bgdbg_pkg::FTS_RST;
      clksel_r  <= bgdbg_pkg::CLKSEL_RST;
    end else if (ctl_wr) begin
      bkpt_en_r <= req_i.wdata[bgdbg_pkg::BKPT_EN_BIT];
      fts_r     <= req_i.wdata[bgdbg_pkg::FTS_BIT];
      clksel_r  <= req_i.wdata[bgdbg_pkg::CLKSEL_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bkpt_addr_r <= bgdbg_pkg::BKPT_ADDR_RST;
    end else if (req_i.cmd == bgdbg_pkg::CMD_BKPT_WRITE) begin
      bkpt_addr_r <= req_i.wdata;
    end
  end

  // Breakpoint ignored entirely while disabled
  assign match = bkpt_en_r && (core_i.addr == bkpt_addr_r) && !active_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      force_pend_r <= 1'b0;
    // A pending force dies when the breakpoint is disabled or turned to tag mode
    end else if (enter_nxt || !permit_r || !bkpt_en_r || !fts_r) begin
      force_pend_r <= 1'b0;
    end else if (match && fts_r) begin
      force_pend_r <= 1'b1;
    end
  end

  // A match on the boundary cycle itself also counts
  assign enter_nxt = permit_r && !active_r &&
                     (bg_cmd ||
                      (((force_pend_r && bkpt_en_r && fts_r) || (match && fts_r)) &&
                       core_i.instr_boundary) ||
                      core_i.queue_end_tagged);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enter_bg_r <= 1'b0;
      tag_r      <= 1'b0;
    end else begin
      enter_bg_r <= enter_nxt;
      tag_r      <= match && !fts_r && core_i.opcode_fetch;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      active_r <= 1'b0;
    end else if (enter_nxt) begin
      active_r <= 1'b1;
    end else if (resume_i) begin
      active_r <= 1'b0;
    end
  end

  // Remembers that background entry came out of wait or stop
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ws_latched_r <= 1'b0;
    end else if (enter_nxt) begin
      ws_latched_r <= core_i.in_wait_stop;
    end else if (resume_i) begin
      ws_latched_r <= 1'b0;
    end
  end

  // Set wins over the clear on resume
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wsf_r <= 1'b0;
    end else if (core_i.mem_cmd_fail_ws) begin
      wsf_r <= 1'b1;
    end else if (resume_i) begin
      wsf_r <= 1'b0;
    end
  end

  always_comb begin
    status_byte = '0;
    status_byte[bgdbg_pkg::PERMIT_BIT]  = permit_r;
    status_byte[bgdbg_pkg::ACTIVE_BIT]  = active_r;
    status_byte[bgdbg_pkg::BKPT_EN_BIT] = bkpt_en_r;
    status_byte[bgdbg_pkg::FTS_BIT]     = fts_r;
    status_byte[bgdbg_pkg::CLKSEL_BIT]  = clksel_r;
    status_byte[bgdbg_pkg::WS_BIT]      = core_i.in_wait_stop || ws_latched_r;
    status_byte[bgdbg_pkg::WSF_BIT]     = wsf_r;
    status_byte[bgdbg_pkg::DVF_BIT]     = 1'b0;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= 1'b0;
      case (req_i.cmd)
        bgdbg_pkg::CMD_READ_STATUS: begin
          rdata_r  <= {{(BKPT_W - CTL_W){1'b0}}, status_byte};
          rvalid_r <= 1'b1;
        end
        bgdbg_pkg::CMD_BKPT_READ: begin
          rdata_r  <= bkpt_addr_r;
          rvalid_r <= 1'b1;
        end
        default: begin
          rdata_r <= rdata_r;
        end
      endcase
    end
  end

  assign rdata_o        = rdata_r;
  assign rvalid_o       = rvalid_r;
  assign enter_bg_o     = enter_bg_r;
  assign tag_opcode_o   = tag_r;
  assign bg_active_o    = active_r;
  assign comm_clk_bus_o = clksel_r;
endmodule
`default_nettype wire

// [test/bgdbg_asserts.sv]
/* Port assertions for the debug register block.
   Bound to its top; sees only the top's ports. */
`timescale 1ns/1ps
`default_nettype none
module bgdbg_asserts (
  input wire logic                   clk_i,
  input wire logic                   resetn_i,
  input wire bgdbg_pkg::serial_req_t req_i,
  input wire bgdbg_pkg::core_stat_t  core_i,
  input wire logic                   resume_i,
  input wire logic [15:0]            rdata_o,
  input wire logic                   rvalid_o,
  input wire logic                   enter_bg_o,
  input wire logic                   tag_opcode_o,
  input wire logic                   bg_active_o,
  input wire logic                   comm_clk_bus_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire st = req_i.cmd == bgdbg_pkg::CMD_READ_STATUS;
  wire rd = st || req_i.cmd == bgdbg_pkg::CMD_BKPT_READ;
  wire wr = req_i.cmd == bgdbg_pkg::CMD_WRITE_CONTROL;
  wire wd3 = req_i.wdata[bgdbg_pkg::CLKSEL_BIT];
  // Only three causes may start background entry
  wire ent = core_i.instr_boundary || core_i.queue_end_tagged
    || req_i.cmd == bgdbg_pkg::CMD_BACKGROUND;
  wire tg = core_i.opcode_fetch && !bg_active_o;
  read_ans_a: assert property (rd |=> rvalid_o) else $error("read unanswered");
  no_spur_a: assert property (rvalid_o |-> $past(rd)) else $error("spurious answer");
  status_fmt_a: assert property (rvalid_o && $past(st) |->
    rdata_o[15:8] == 8'h00 && !rdata_o[0] && rdata_o[6] == $past(bg_active_o))
    else $error("bad status byte");
  clk_wr_a: assert property (wr |=> comm_clk_bus_o == $past(wd3)) else $error("clk sel");
  clk_hold_a: assert property (!wr |=> $stable(comm_clk_bus_o)) else $error("clk drift");
  bg_rise_a: assert property ($rose(bg_active_o) |-> enter_bg_o) else $error("rise");
  resume_clear_a: assert property (resume_i |=> !bg_active_o) else $error("no resume");
  entry_cause_a: assert property (enter_bg_o |-> $past(ent)) else $error("stray entry");
  tag_cause_a: assert property (tag_opcode_o |-> $past(tg)) else $error("stray tag");
endmodule
bind background_debug_control_regs bgdbg_asserts i_chk (.clk_i(clk_i), .resetn_i(resetn_i),
  .req_i(req_i), .core_i(core_i), .resume_i(resume_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .enter_bg_o(enter_bg_o), .tag_opcode_o(tag_opcode_o),
  .bg_active_o(bg_active_o), .comm_clk_bus_o(comm_clk_bus_o));
`default_nettype wire

// [test/debug_host_model.sv]
/* Debug host model: one decoded serial command per call.
   Assumes the block answers reads one cycle later. */
`timescale 1ns/1ps
`default_nettype none
module debug_host_model (
  input  wire logic                   clk_i,
  input  wire logic [15:0]            rdata_i,
  input  wire logic                   rvalid_i,
  output var  bgdbg_pkg::serial_req_t req_o
);
  initial req_o = '{cmd: bgdbg_pkg::CMD_NONE, wdata: 16'h0000};
  // Released data is inverted so a stale value never matches
  task automatic send(input bgdbg_pkg::cmd_t c, input logic [15:0] d);
    @(posedge clk_i);
    req_o <= '{cmd: c, wdata: d};
    @(posedge clk_i);
    req_o <= '{cmd: bgdbg_pkg::CMD_NONE, wdata: ~d};
    #1;
  endtask
  // No answer gives unknown, so the caller's compare fails
  task automatic get(input bgdbg_pkg::cmd_t c, output logic [15:0] q);
    send(c, 16'h0000);
    q = rvalid_i ? rdata_i : 16'hxxxx;
  endtask
  task automatic ctl(input logic [7:0] d);
    send(bgdbg_pkg::CMD_WRITE_CONTROL, {8'h00, d});
  endtask
  // Status read: one read-status command, the answer returned in q
  task automatic stat(output logic [15:0] q);
    get(bgdbg_pkg::CMD_READ_STATUS, q);
  endtask
endmodule
`default_nettype wire

// [test/tb_background_debug_control_regs.sv]
/* Bench for the debug register block: host model on the command
   port, core status and resume driven here. */
`timescale 1ns/1ps
`default_nettype none
module tb_background_debug_control_regs;
  logic clk_i = 1'b0, resetn_i = 1'b0, resume_i = 1'b0;
  bgdbg_pkg::core_stat_t core_i = '0;
  bgdbg_pkg::serial_req_t req_i;
  logic [15:0] rdata_o, q;
  logic rvalid_o, enter_bg_o, tag_opcode_o, bg_active_o, comm_clk_bus_o;
  int err_count = 0;
  int comparisons = 0;
  // Byte written, then status expected
  logic [15:0] rows [5] = '{16'h0808, 16'h4700, 16'h3030, 16'h8080, 16'h0080};
  always #5 clk_i = ~clk_i;
  background_debug_control_regs i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i),
    .core_i(core_i), .resume_i(resume_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .enter_bg_o(enter_bg_o), .tag_opcode_o(tag_opcode_o), .bg_active_o(bg_active_o),
    .comm_clk_bus_o(comm_clk_bus_o));
  debug_host_model i_host (.clk_i(clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
    .req_o(req_i));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // Core event for one cycle; e is {enter, tag} a cycle later
  task automatic step(input logic [20:0] c, input logic [1:0] e);
    @(posedge clk_i);
    core_i <= c;
    @(posedge clk_i);
    core_i <= '0;
    #1;
    chk({14'h0, enter_bg_o, tag_opcode_o}, {14'h0, e});
  endtask
  task automatic leave_bg;
    @(posedge clk_i);
    resume_i <= 1'b1;
    @(posedge clk_i);
    resume_i <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    i_host.stat(q);
    chk(q, 16'h0000);
    // Background command refused while permit is still clear
    i_host.send(bgdbg_pkg::CMD_BACKGROUND, 16'h0000);
    i_host.stat(q);
    chk(q, 16'h0000);
    chk(16'(bg_active_o), 16'h0000);
    for (int i = 0; i < 5; i++) begin
      i_host.ctl(rows[i][15:8]);
      i_host.stat(q);
      chk(q, {8'h00, rows[i][7:0]});
      chk(16'(comm_clk_bus_o), 16'(rows[i][bgdbg_pkg::CLKSEL_BIT]));
    end
    i_host.send(bgdbg_pkg::CMD_BKPT_WRITE, 16'h1234);
    i_host.get(bgdbg_pkg::CMD_BKPT_READ, q);
    chk(q, 16'h1234);
    @(posedge clk_i);
    core_i <= 21'h100000;
    i_host.send(bgdbg_pkg::CMD_BACKGROUND, 16'h0000);
    i_host.stat(q);
    chk(q, 16'h00c4);
    chk(16'(bg_active_o), 16'h0001);
    @(posedge clk_i);
    core_i <= '0;
    // Breakpoint armed in background state; permit already set, bit 7 written as 1 again
    i_host.ctl(8'hb0);
    i_host.stat(q);
    chk(q, 16'h00f4);
    leave_bg();
    i_host.stat(q);
    chk(q, 16'h00b0);
    chk(16'(bg_active_o), 16'h0000);
    step(21'h080000, 2'b00);
    i_host.stat(q);
    chk(q, 16'h00b2);
    // Recovery: background, confirm, then resume clears the failure flag
    i_host.send(bgdbg_pkg::CMD_BACKGROUND, 16'h0000);
    i_host.stat(q);
    chk(q, 16'h00f2);
    leave_bg();
    i_host.stat(q);
    chk(q, 16'h00b0);
    step(21'h041234, 2'b10);
    i_host.ctl(8'ha0);
    leave_bg();
    step(21'h021234, 2'b01);
    step(21'h010000, 2'b10);
    i_host.ctl(8'h90);
    leave_bg();
    step(21'h061234, 2'b00);
    i_host.ctl(8'h80);
    step(21'h021234, 2'b00);
    // Mid-run reset clears permit and the breakpoint address
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    i_host.stat(q);
    chk(q, 16'h0000);
    i_host.get(bgdbg_pkg::CMD_BKPT_READ, q);
    chk(q, bgdbg_pkg::BKPT_ADDR_RST);
    // Live wait/stop shows without any background entry
    @(posedge clk_i);
    core_i <= 21'h100000;
    i_host.stat(q);
    chk(q, 16'h0004);
    @(posedge clk_i);
    core_i <= '0;
    tally_and_finish();
  end
endmodule
`default_nettype wire
